// file: rtl/byte_alu_pkg.sv
// Purpose: shared constants, types and decode helpers for the byte alu
// Assumes: ahb-lite register access, 32-bit data, word transfers only
// Notes: byte addresses below are the bus byte offsets of each register
package byte_alu_pkg;

    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam int BUS_AW = 12;

    // register map, byte offsets
    localparam logic [BUS_AW-1:0] OFS_INSTR = 12'h000;
    localparam logic [BUS_AW-1:0] OFS_WORK = 12'h004;
    localparam logic [BUS_AW-1:0] OFS_STAT = 12'h008;
    localparam logic [BUS_AW-1:0] OFS_FILE_BASE = 12'h200;
    localparam logic [BUS_AW-1:0] OFS_FILE_LAST = 12'h3fc;

    // instruction word fields
    localparam int INSTR_OP_LSB = 0;
    localparam int INSTR_DEST_BIT = 4;
    localparam int INSTR_FADDR_LSB = 8;
    localparam int INSTR_LIT_LSB = 16;
    localparam int INSTR_USED_W = 24;

    // status word fields
    localparam int STAT_C_BIT = 0;
    localparam int STAT_DIGIT_BIT = 1;
    localparam int STAT_Z_BIT = 2;

    // reset values
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [INSTR_USED_W-1:0] INSTR_RST = 24'h000000;
    localparam logic FLAG_RST = 1'b0;

    // destination select
    localparam logic DEST_WORK = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    localparam logic [1:0] HTRANS_IDLE = 2'b00;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0]
    {
        OP_SUB_WORKING_FROM_FILE = 2'b00,
        OP_XOR_LITERAL_WORKING = 2'b01,
        OP_SWAP_NIBBLES_FILE = 2'b10,
        OP_XOR_WORKING_FILE = 2'b11
    } alu_op_e;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_RD_WAIT = 2'b10,
        ST_RD_DONE = 2'b11
    } bus_st_e;

    function automatic logic is_file_addr(input logic [BUS_AW-1:0] a);
        is_file_addr = (a >= OFS_FILE_BASE) && (a <= OFS_FILE_LAST);
    endfunction : is_file_addr

    function automatic logic [FADDR_W-1:0] file_index(
        input logic [BUS_AW-1:0] a);
        logic [BUS_AW-1:0] d;
        d = a - OFS_FILE_BASE;
        file_index = d[FADDR_W+1:2];
    endfunction : file_index

endpackage : byte_alu_pkg

// file: rtl/alu_if.sv
// Purpose: carries operands and results between sequencer and datapath
// Assumes: purely combinational exchange within one clock cycle
// Notes: ctl side drives operands, alu side drives results and flags
`timescale 1ns/1ps
interface alu_if;
    import byte_alu_pkg::*;
    alu_op_e op;
    logic dest;
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] f;
    logic [DATA_W-1:0] lit;
    logic [DATA_W-1:0] result;
    logic to_file;
    logic c;
    logic dig_c;
    logic z;
    logic upd_cdc;
    logic upd_z;

    modport ctl (output op, dest, w, f, lit,
                 input result, to_file, c, dig_c, z, upd_cdc, upd_z);
    modport alu (input op, dest, w, f, lit,
                 output result, to_file, c, dig_c, z, upd_cdc, upd_z);
endinterface : alu_if

// file: rtl/byte_alu_core.sv
// Purpose: combinational byte datapath for subtract, xor and swap
// Assumes: operands stable for the whole cycle
// Notes: flags are offered with update enables; caller commits them
`timescale 1ns/1ps
module byte_alu_core
(
    // operand and result bundle
    alu_if.alu ab
);
    import byte_alu_pkg::*;

    always_comb
    begin
        ab.result = ab.w;
        ab.c = 1'b0;
        ab.dig_c = 1'b0;
        ab.upd_cdc = 1'b0;
        ab.upd_z = 1'b1;
        ab.to_file = (ab.dest == DEST_FILE);
        unique case (ab.op)
            OP_SUB_WORKING_FROM_FILE:
            begin
                ab.result = ab.f - ab.w;
                ab.c = (ab.w <= ab.f);
                ab.dig_c = (ab.w[3:0] <= ab.f[3:0]);
                ab.upd_cdc = 1'b1;
            end
            OP_XOR_LITERAL_WORKING:
            begin
                ab.result = ab.w ^ ab.lit;
                ab.to_file = 1'b0;
            end
            OP_SWAP_NIBBLES_FILE:
            begin
                ab.result = {ab.f[3:0], ab.f[7:4]};
                ab.upd_z = 1'b0;
            end
            OP_XOR_WORKING_FILE:
            begin
                ab.result = ab.w ^ ab.f;
            end
        endcase
        ab.z = (ab.result == '0);
    end

endmodule : byte_alu_core

// file: rtl/byte_alu_sub_xor_swap.sv
// Purpose: byte alu with working reg, 128-byte file and flags on ahb-lite
// Assumes: single word transfers; writing the instruction word executes it
// Notes: reads insert one wait state; writes take none
//
// Summary of operation
// - subtract gives file minus working, eight-bit two's complement
// - carry set when working <= file; digit carry likewise on low nibbles
// - destination bit 0 writes working, 1 writes file; file index 0..127
// - literal xor writes working, changes only the zero flag
// - swap exchanges file nibbles into destination, flags untouched
// - working xor file, routed by destination bit, zero flag only
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module byte_alu_sub_xor_swap
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // state for the core around
    output logic [byte_alu_pkg::DATA_W-1:0] working_reg,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag
);
    import byte_alu_pkg::*;

    bus_st_e st_r;
    bus_st_e st_nxt;
    logic [BUS_AW-1:0] addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_mux;
    logic [INSTR_USED_W-1:0] instr_r;
    logic [DATA_W-1:0] w_r;
    logic c_r;
    logic dig_c_r;
    logic z_r;
    logic [DATA_W-1:0] file_mem [FILE_DEPTH];
    logic accept;
    logic wr_act;
    logic exec;
    logic [FADDR_W-1:0] ex_faddr;
    logic bus_file_wr;

    alu_if ab ();

    byte_alu_core u_core
    (
        .ab(ab.alu)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus sequencing
    assign accept = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
    assign wr_act = (st_r == ST_WRITE);
    assign hreadyout = (st_r != ST_RD_WAIT);
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_r;

    always_comb
    begin
        st_nxt = ST_IDLE;
        unique case (st_r)
            ST_RD_WAIT:
            begin
                st_nxt = ST_RD_DONE;
            end
            ST_IDLE, ST_WRITE, ST_RD_DONE:
            begin
                if (accept)
                begin
                    st_nxt = hwrite ? ST_WRITE : ST_RD_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st_r <= ST_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            addr_r <= '0;
        end
        else if (accept)
        begin
            addr_r <= haddr[BUS_AW-1:0];
        end
    end

    always_comb
    begin
        rd_mux = '0;
        if (addr_r == OFS_INSTR)
        begin
            rd_mux[INSTR_USED_W-1:0] = instr_r;
        end
        else if (addr_r == OFS_WORK)
        begin
            rd_mux[DATA_W-1:0] = w_r;
        end
        else if (addr_r == OFS_STAT)
        begin
            rd_mux[STAT_C_BIT] = c_r;
            rd_mux[STAT_DIGIT_BIT] = dig_c_r;
            rd_mux[STAT_Z_BIT] = z_r;
        end
        else if (is_file_addr(addr_r))
        begin
            rd_mux[DATA_W-1:0] = file_mem[file_index(addr_r)];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            hrdata_r <= '0;
        end
        else if (st_r == ST_RD_WAIT)
        begin
            hrdata_r <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction issue
    assign exec = wr_act && (addr_r == OFS_INSTR);
    assign ex_faddr = hwdata[INSTR_FADDR_LSB +: FADDR_W];
    assign bus_file_wr = wr_act && is_file_addr(addr_r);
    assign ab.op = alu_op_e'(hwdata[INSTR_OP_LSB +: 2]);
    assign ab.dest = hwdata[INSTR_DEST_BIT];
    assign ab.lit = hwdata[INSTR_LIT_LSB +: DATA_W];
    assign ab.w = w_r;
    assign ab.f = file_mem[ex_faddr];

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            instr_r <= INSTR_RST;
        end
        else if (exec)
        begin
            instr_r <= hwdata[INSTR_USED_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // working register
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            w_r <= WORK_RST;
        end
        else if (wr_act && (addr_r == OFS_WORK))
        begin
            w_r <= hwdata[DATA_W-1:0];
        end
        else if (exec && !ab.to_file)
        begin
            w_r <= ab.result;
        end
    end

    // file registers
    always_ff @(posedge core_clk)
    begin
        if (bus_file_wr)
        begin
            file_mem[file_index(addr_r)] <= hwdata[DATA_W-1:0];
        end
        else if (exec && ab.to_file)
        begin
            file_mem[ex_faddr] <= ab.result;
        end
    end

    // status flags
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            c_r <= FLAG_RST;
            dig_c_r <= FLAG_RST;
            z_r <= FLAG_RST;
        end
        else if (wr_act && (addr_r == OFS_STAT))
        begin
            c_r <= hwdata[STAT_C_BIT];
            dig_c_r <= hwdata[STAT_DIGIT_BIT];
            z_r <= hwdata[STAT_Z_BIT];
        end
        else if (exec)
        begin
            if (ab.upd_cdc)
            begin
                c_r <= ab.c;
                dig_c_r <= ab.dig_c;
            end
            if (ab.upd_z)
            begin
                z_r <= ab.z;
            end
        end
    end

    assign working_reg = w_r;
    assign carry_flag = c_r;
    assign digit_carry_flag = dig_c_r;
    assign zero_flag = z_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic [DATA_W-1:0] f_now;
    assign f_now = ab.f;

    sequence seq_exec_op(alu_op_e o);
        exec && (ab.op == o);
    endsequence

    sequence seq_read_start;
        (st_r == ST_RD_WAIT) && !hreadyout;
    endsequence

    chk_sub_value: assert property (
        seq_exec_op(OP_SUB_WORKING_FROM_FILE) ##0 (ab.dest == DEST_WORK)
        |=> w_r == DATA_W'($past(f_now) - $past(w_r)))
        else $error("subtract result wrong");

    chk_sub_flags: assert property (
        seq_exec_op(OP_SUB_WORKING_FROM_FILE)
        |=> (c_r == ($past(w_r) <= $past(f_now)))
            && (dig_c_r == ($past(w_r[3:0]) <= $past(f_now[3:0]))))
        else $error("subtract carry flags wrong");

    chk_dest_file: assert property (
        exec && ab.to_file
        |=> (file_mem[$past(ex_faddr)] == $past(ab.result))
            && (w_r == $past(w_r)))
        else $error("file destination not honoured");

    chk_xor_lit_flags: assert property (
        seq_exec_op(OP_XOR_LITERAL_WORKING)
        |=> (w_r == ($past(w_r) ^ $past(ab.lit))) && $stable(c_r)
            && $stable(dig_c_r))
        else $error("literal xor wrong");

    chk_swap_flags: assert property (
        seq_exec_op(OP_SWAP_NIBBLES_FILE) ##0 (ab.dest == DEST_WORK)
        |=> (w_r == {$past(f_now[3:0]), $past(f_now[7:4])})
            && $stable(c_r) && $stable(dig_c_r) && $stable(z_r))
        else $error("swap wrong or flags moved");

    chk_xor_file_value: assert property (
        seq_exec_op(OP_XOR_WORKING_FILE) ##0 (ab.dest == DEST_WORK)
        |=> (w_r == ($past(w_r) ^ $past(f_now))) && $stable(c_r))
        else $error("working xor file wrong");

    chk_zero_flag: assert property (
        exec && (ab.op != OP_SWAP_NIBBLES_FILE)
        |=> z_r == ($past(ab.result) == 8'h00))
        else $error("zero flag wrong");

    chk_read_wait: assert property (
        hsel && hready && htrans[HTRANS_ACTIVE_BIT] && !hwrite
        |=> seq_read_start ##1 hreadyout ##0 (hrdata == $past(rd_mux)))
        else $error("read answer timing wrong");

endmodule : byte_alu_sub_xor_swap

// file: verification/testbench.sv
// Purpose: self-checking bench for the byte alu over ahb-lite
// Assumes: hready looped from hreadyout, word transfers only
// Notes: expectations worked out here from operands and flags
`timescale 1ns/1ps
module testbench;
    import byte_alu_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic [DATA_W-1:0] working_reg;
    logic carry_flag;
    logic digit_carry_flag;
    logic zero_flag;
    int err_total = 0;
    int compares = 0;

    byte_alu_sub_xor_swap i_dut
    (
        .core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .working_reg(working_reg),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag)
    );

    always #12.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : check

    // one single transfer, held until hready seen high
    task automatic bus(input logic wr, input logic [31:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= HTRANS_IDLE;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
        check("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    endtask : bus

    // load operands, execute, read back every result place
    task automatic do_op(input alu_op_e op, input logic dest,
        input logic [6:0] idx, input logic [7:0] w, input logic [7:0] f,
        input logic [7:0] lit, input logic [2:0] st);
        logic [31:0] rd;
        logic [31:0] fa;
        logic [7:0] r;
        logic [2:0] ex;
        logic tf;
        fa = 32'(OFS_FILE_BASE) + {23'h0, idx, 2'b00};
        ex = st;
        tf = (dest == DEST_FILE) && (op != OP_XOR_LITERAL_WORKING);
        r = (op == OP_SUB_WORKING_FROM_FILE) ? f - w :
            (op == OP_SWAP_NIBBLES_FILE) ? {f[3:0], f[7:4]} :
            (op == OP_XOR_LITERAL_WORKING) ? w ^ lit : w ^ f;
        if (op == OP_SUB_WORKING_FROM_FILE)
            ex[1:0] = {w[3:0] <= f[3:0], w <= f};
        if (op != OP_SWAP_NIBBLES_FILE)
            ex[STAT_Z_BIT] = (r == 8'h00);
        bus(1'b1, fa, {24'h0, f}, rd);
        bus(1'b1, 32'(OFS_WORK), {24'h0, w}, rd);
        bus(1'b1, 32'(OFS_STAT), {29'h0, st}, rd);
        bus(1'b1, 32'(OFS_INSTR),
            {8'h00, lit, 1'b0, idx, 3'b000, dest, 2'b00, op}, rd);
        // results show in the cycle after the executing edge
        @(posedge core_clk);
        check("flag pins", {29'h0, ex},
            {29'h0, zero_flag, digit_carry_flag, carry_flag});
        check("working pin", {24'h0, tf ? w : r}, {24'h0, working_reg});
        bus(1'b0, 32'(OFS_WORK), 32'h0, rd);
        check("work reg", {24'h0, tf ? w : r}, rd);
        bus(1'b0, fa, 32'h0, rd);
        check("file reg", {24'h0, tf ? r : f}, rd);
        bus(1'b0, 32'(OFS_STAT), 32'h0, rd);
        check("status reg", {29'h0, ex}, rd);
    endtask : do_op

    ////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        logic [31:0] rd;
        check("pins", 32'h0, {20'h0, working_reg, carry_flag,
            digit_carry_flag, zero_flag, hready ^ 1'b1});
        bus(1'b0, 32'(OFS_INSTR), 32'h0, rd);
        check("instr rst", 32'h0, rd);
        bus(1'b0, 32'(OFS_STAT), 32'h0, rd);
        check("status rst", 32'h0, rd);
        bus(1'b1, 32'h00000100, 32'h000000a5, rd);
        bus(1'b0, 32'h00000100, 32'h0, rd);
        check("unmapped", 32'h0, rd);
        $display("test reset done");
    endtask : test_reset

    task automatic test_sub();
        do_op(OP_SUB_WORKING_FROM_FILE, 1'b0, 7'h00,
            8'h05, 8'h05, 8'h00, 3'h0);
        do_op(OP_SUB_WORKING_FROM_FILE, 1'b1, 7'h7f,
            8'h10, 8'h0f, 8'h00, 3'h7);
        do_op(OP_SUB_WORKING_FROM_FILE, 1'b0, 7'h2a,
            8'h0f, 8'h10, 8'h00, 3'h4);
        do_op(OP_SUB_WORKING_FROM_FILE, 1'b1, 7'h01,
            8'hff, 8'h00, 8'h00, 3'h2);
        $display("test sub done");
    endtask : test_sub

    task automatic test_xor_lit();
        do_op(OP_XOR_LITERAL_WORKING, 1'b1, 7'h03,
            8'hff, 8'h3c, 8'hff, 3'h3);
        do_op(OP_XOR_LITERAL_WORKING, 1'b0, 7'h03,
            8'h5a, 8'h00, 8'h0f, 3'h4);
        $display("test xor literal done");
    endtask : test_xor_lit

    task automatic test_swap();
        do_op(OP_SWAP_NIBBLES_FILE, 1'b1, 7'h7f,
            8'h00, 8'h1e, 8'h00, 3'h7);
        do_op(OP_SWAP_NIBBLES_FILE, 1'b0, 7'h00,
            8'h33, 8'hc0, 8'h00, 3'h0);
        $display("test swap done");
    endtask : test_swap

    task automatic test_xor_file();
        do_op(OP_XOR_WORKING_FILE, 1'b0, 7'h40,
            8'h96, 8'h96, 8'h00, 3'h3);
        do_op(OP_XOR_WORKING_FILE, 1'b1, 7'h41,
            8'h81, 8'h18, 8'h00, 3'h4);
        $display("test xor file done");
    endtask : test_xor_file

    // reset again in mid-run, with working reg and instruction non-zero
    task automatic test_mid_reset();
        logic [31:0] rd;
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check("pins again", 32'h0, {20'h0, working_reg, carry_flag,
            digit_carry_flag, zero_flag, hready ^ 1'b1});
        check("rdata again", 32'h0, hrdata);
        bus(1'b0, 32'(OFS_INSTR), 32'h0, rd);
        check("instr again", 32'h0, rd);
        $display("test mid reset done");
    endtask : test_mid_reset

    ////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        test_reset();
        test_sub();
        test_xor_lit();
        test_swap();
        test_xor_file();
        test_mid_reset();
        complete_run();
    end

    // watchdog well beyond the 75 transfers above
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        complete_run();
    end
endmodule : testbench
